// ### rtl/adc_digital_control.sv
// Purpose: clock select, sequencing, compare and pin control of the ADC
// Assumes: all inputs synchronous to clk except hw_trigger_input and alternate_clock
// Notes: converter_clock is a divided square wave made on clk
`default_nettype none
module adc_digital_control (
  input  wire logic                     clk,
  input  wire logic                     rst,
  input  wire logic [3:0]               addr,
  input  wire logic [7:0]               wr_data,
  input  wire logic                     wr_en,
  input  wire logic                     rd_en,
  output logic [7:0]                    rd_data,
  input  wire logic                     alternate_clock,
  input  wire logic                     stop_mode,
  input  wire logic                     hw_trigger_input,
  input  wire logic [11:0]              conv_result,
  output logic                          converter_clock,
  output logic                          conv_start,
  output logic                          busy,
  output logic                          cmp_match,
  output logic                          low_power_select,
  output logic                          long_sample_select,
  input  wire logic [adc_pkg::PINS-1:0] port_out,
  input  wire logic [adc_pkg::PINS-1:0] port_oe_n,
  input  wire logic [adc_pkg::PINS-1:0] port_pullup,
  input  wire logic [adc_pkg::PINS-1:0] pin_in,
  output logic [adc_pkg::PINS-1:0]      pin_out,
  output logic [adc_pkg::PINS-1:0]      pin_oe_n,
  output logic [adc_pkg::PINS-1:0]      pin_pullup,
  output logic [adc_pkg::PINS-1:0]      port_read
);
  localparam int ASYNC_WAIT = 4;
  adc_pkg::adc_cfg_t   cfg;
  adc_pkg::adc_ctl_t   ctl;
  adc_pkg::adc_state_t state;
  adc_pkg::adc_state_t next_state;
  logic [7:0]  compare_high_reg;
  logic [7:0]  compare_low_reg;
  logic [7:0]  pin_control [3];
  logic [adc_pkg::PINS-1:0] pc_all;
  logic [11:0] result;
  logic        done;
  logic        sw_start;
  logic        hw_start;
  logic        start;
  logic        bus_half;
  logic        alt_s1, alt_s2, alt_s3;
  logic [1:0]  osc_cnt;
  logic        osc_tick;
  logic        src_tick;
  logic [2:0]  div_cnt;
  logic [2:0]  div_mask;
  logic        conv_tick;
  logic        trg_s1, trg_s2, trg_s3;
  logic        trg_rise;
  logic [4:0]  cnt;
  logic [4:0]  next_cnt;
  logic        finish;
  logic [11:0] res_m;
  logic [11:0] cv;
  logic        match;
  logic [4:0]  sample_len;
  logic [4:0]  bit_len;

  // -----------------------------------------------------------------
  // register port
  // -----------------------------------------------------------------
  assign sw_start = wr_en && addr == adc_pkg::REG_CTL
                    && wr_data[adc_pkg::CTL_START];

  // configuration and compare registers
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cfg              <= adc_pkg::adc_cfg_t'(adc_pkg::RST_BYTE);
      ctl              <= adc_pkg::adc_ctl_t'(adc_pkg::RST_BYTE);
      compare_high_reg <= adc_pkg::RST_BYTE;
      compare_low_reg  <= adc_pkg::RST_BYTE;
    end
    else if (wr_en)
    begin
      case (addr)
        adc_pkg::REG_CVH: compare_high_reg <= wr_data;
        adc_pkg::REG_CVL: compare_low_reg <= wr_data;
        adc_pkg::REG_CFG: cfg <= adc_pkg::adc_cfg_t'(wr_data);
        adc_pkg::REG_CTL:
        begin
          ctl       <= adc_pkg::adc_ctl_t'(wr_data);
          ctl.start <= 1'b0; // start is a pulse, reads zero
        end
        default: ;
      endcase
    end
  end

  // pin control registers, one byte per group of eight pins
  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : g_pc
      always_ff @(posedge clk or posedge rst)
      begin
        if (rst)
          pin_control[g] <= adc_pkg::RST_BYTE;
        else if (wr_en && addr == adc_pkg::REG_PC1 + 4'(g))
          pin_control[g] <= wr_data;
      end
    end
  endgenerate
  assign pc_all = {pin_control[2], pin_control[1], pin_control[0]};

  // read data, valid the cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      rd_data <= adc_pkg::RST_BYTE;
    else if (!rd_en)
      rd_data <= adc_pkg::RST_BYTE;
    else
    begin
      case (addr)
        adc_pkg::REG_CVH:  rd_data <= compare_high_reg;
        adc_pkg::REG_CVL:  rd_data <= compare_low_reg;
        adc_pkg::REG_CFG:  rd_data <= cfg;
        adc_pkg::REG_CTL:  rd_data <= ctl;
        adc_pkg::REG_STAT: rd_data <= {5'h00, cmp_match, done, busy};
        adc_pkg::REG_RESH: rd_data <= {4'h0, result[11:8]};
        adc_pkg::REG_RESL: rd_data <= result[7:0];
        adc_pkg::REG_PC1:  rd_data <= pin_control[0];
        adc_pkg::REG_PC2:  rd_data <= pin_control[1];
        adc_pkg::REG_PC3:  rd_data <= pin_control[2];
        default:           rd_data <= adc_pkg::RST_BYTE;
      endcase
    end
  end

  // -----------------------------------------------------------------
  // converter clock source and divider
  // -----------------------------------------------------------------
  // bus/2 phase, alternate clock edge finder, internal oscillator
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      bus_half <= 1'b0;
      alt_s1   <= 1'b0;
      alt_s2   <= 1'b0;
      alt_s3   <= 1'b0;
      osc_cnt  <= 2'h0;
    end
    else
    begin
      bus_half <= ~bus_half;
      alt_s1   <= alternate_clock;
      alt_s2   <= alt_s1;
      alt_s3   <= alt_s2;
      osc_cnt  <= osc_tick ? 2'h0 : osc_cnt + 2'h1;
    end
  end
  assign osc_tick = osc_cnt == adc_pkg::ASYNC_DIV;

  // only the internal oscillator survives wait and stop
  always_comb
  begin
    case (cfg.clock_source_select)
      adc_pkg::SRC_BUS:  src_tick = !stop_mode;
      adc_pkg::SRC_BUS2: src_tick = !stop_mode && bus_half;
      adc_pkg::SRC_ALT:  src_tick = !stop_mode && alt_s2 && !alt_s3;
      default:           src_tick = osc_tick;
    endcase
  end

  // divide by 1, 2, 4 or 8 source ticks
  assign div_mask  = 3'(4'(4'h1 << cfg.clock_divide_select) - 4'h1);
  assign conv_tick = src_tick && ((div_cnt & div_mask) == div_mask);

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      div_cnt         <= 3'h0;
      converter_clock <= 1'b0;
    end
    else
    begin
      if (src_tick)
        div_cnt <= div_cnt + 3'h1;
      if (conv_tick)
        converter_clock <= ~converter_clock;
    end
  end

  // -----------------------------------------------------------------
  // hardware trigger
  // -----------------------------------------------------------------
  // two-flop synchroniser, edge found between second and third stage
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      trg_s1 <= 1'b0;
      trg_s2 <= 1'b0;
      trg_s3 <= 1'b0;
    end
    else
    begin
      trg_s1 <= hw_trigger_input;
      trg_s2 <= trg_s1;
      trg_s3 <= trg_s2;
    end
  end
  assign trg_rise = trg_s2 && !trg_s3;
  // busy covers a whole continuous series, so later edges drop out
  assign hw_start = ctl.trigger_select && trg_rise && !busy;
  assign start    = (sw_start && !ctl.trigger_select) || hw_start;

  // -----------------------------------------------------------------
  // conversion sequencer
  // -----------------------------------------------------------------
  assign sample_len = cfg.long_sample_select ? adc_pkg::SAMPLE_LONG
                                             : adc_pkg::SAMPLE_SHORT;
  always_comb
  begin
    case (cfg.mode)
      adc_pkg::MODE_12: bit_len = adc_pkg::BITS_12;
      adc_pkg::MODE_10: bit_len = adc_pkg::BITS_10;
      default:          bit_len = adc_pkg::BITS_8;
    endcase
  end

  // sample phase then one converter clock edge (half period) per bit
  always_comb
  begin
    next_state = state;
    next_cnt   = cnt;
    finish     = 1'b0;
    case (state)
      adc_pkg::ADC_IDLE: ;
      adc_pkg::ADC_SAMPLE:
        if (conv_tick)
        begin
          next_cnt = cnt - 5'h01;
          if (cnt == 5'h01)
          begin
            next_state = adc_pkg::ADC_CONV;
            next_cnt   = bit_len;
          end
        end
      adc_pkg::ADC_CONV:
        if (conv_tick)
        begin
          next_cnt = cnt - 5'h01;
          if (cnt == 5'h01)
          begin
            finish     = 1'b1;
            next_state = ctl.continuous ? adc_pkg::ADC_SAMPLE
                                        : adc_pkg::ADC_IDLE;
            next_cnt   = sample_len;
          end
        end
      default: next_state = adc_pkg::ADC_IDLE;
    endcase
    if (start)
    begin
      next_state = adc_pkg::ADC_SAMPLE;
      next_cnt   = sample_len;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state      <= adc_pkg::ADC_IDLE;
      cnt        <= 5'h00;
      busy       <= 1'b0;
      conv_start <= 1'b0;
    end
    else
    begin
      state      <= next_state;
      cnt        <= next_cnt;
      busy       <= next_state != adc_pkg::ADC_IDLE;
      conv_start <= start || (finish && ctl.continuous);
    end
  end

  // -----------------------------------------------------------------
  // result and compare
  // -----------------------------------------------------------------
  // mask result and compare value to the active resolution
  always_comb
  begin
    case (cfg.mode)
      adc_pkg::MODE_12:
      begin
        res_m = conv_result;
        cv    = {compare_high_reg[3:0], compare_low_reg};
      end
      adc_pkg::MODE_10:
      begin
        res_m = {2'h0, conv_result[9:0]};
        cv    = {2'h0, compare_high_reg[1:0], compare_low_reg};
      end
      default:
      begin
        res_m = {4'h0, conv_result[7:0]};
        cv    = {4'h0, compare_low_reg};
      end
    endcase
  end
  assign match = ctl.cmp_ge ? (res_m >= cv) : (res_m < cv);

  // done is cleared by reading the low result byte; a finish wins
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      result    <= 12'h000;
      done      <= 1'b0;
      cmp_match <= 1'b0;
    end
    else
    begin
      if (finish)
      begin
        result    <= res_m;
        cmp_match <= ctl.cmp_en && match;
      end
      if (finish)
        done <= 1'b1;
      else if (rd_en && addr == adc_pkg::REG_RESL)
        done <= 1'b0;
    end
  end

  assign low_power_select   = cfg.low_power_select;
  assign long_sample_select = cfg.long_sample_select;

  // -----------------------------------------------------------------
  // analog pin override
  // -----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pin_out    <= '0;
      pin_oe_n   <= '1;
      pin_pullup <= '0;
      port_read  <= '0;
    end
    else
    begin
      pin_out    <= port_out;
      pin_oe_n   <= port_oe_n | pc_all;
      port_read  <= pin_in & ~pc_all;
      pin_pullup <= port_pullup & ~pc_all;
    end
  end

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  sequence s_hw_edge_busy;
    trg_rise && ctl.trigger_select && busy && !sw_start;
  endsequence
  sequence s_finish_mode(logic [1:0] m);
    finish && cfg.mode == m && ctl.cmp_en;
  endsequence

  chk_cmp_ten_bit: assert property (@(posedge clk) disable iff (rst)
    s_finish_mode(adc_pkg::MODE_10) |=> cmp_match ==
      ($past(ctl.cmp_ge) ==
       ($past({conv_result[9:8], conv_result[7:0]}) >=
        $past({compare_high_reg[1:0], compare_low_reg}))))
    else $error("10-bit compare wrong");
  chk_cmp_eight_bit: assert property (@(posedge clk) disable iff (rst)
    s_finish_mode(adc_pkg::MODE_8) |=> cmp_match ==
      ($past(ctl.cmp_ge) == ($past(conv_result[7:0]) >=
                             $past(compare_low_reg))))
    else $error("8-bit compare wrong");
  chk_result_low: assert property (@(posedge clk) disable iff (rst)
    finish |=> result[7:0] == $past(conv_result[7:0]) && done)
    else $error("result low byte not stored");
  chk_power_bit: assert property (@(posedge clk) disable iff (rst)
    wr_en && addr == adc_pkg::REG_CFG |=>
      low_power_select == $past(wr_data[7]))
    else $error("low power bit not taken");
  chk_div_by_two: assert property (@(posedge clk) disable iff (rst)
    conv_tick && cfg.clock_source_select == adc_pkg::SRC_BUS &&
    cfg.clock_divide_select == 2'h1 && !stop_mode &&
    !(wr_en && addr == adc_pkg::REG_CFG) |=> !conv_tick)
    else $error("divide by two ticks twice");
  chk_async_stop: assert property (@(posedge clk) disable iff (rst)
    stop_mode && cfg.clock_source_select == adc_pkg::SRC_ASYN
      |-> ##[0:ASYNC_WAIT] src_tick)
    else $error("async clock halted in stop");
  chk_bus_stop: assert property (@(posedge clk) disable iff (rst)
    stop_mode && cfg.clock_source_select != adc_pkg::SRC_ASYN |-> !src_tick)
    else $error("bus clock runs in stop");
  chk_pin_off: assert property (@(posedge clk) disable iff (rst)
    1'b1 |=> (pin_oe_n & $past(pc_all)) == $past(pc_all) &&
      (port_read & $past(pc_all)) == '0 &&
      (pin_pullup & $past(pc_all)) == '0)
    else $error("analog pin not released");
  chk_hw_start: assert property (@(posedge clk) disable iff (rst)
    trg_rise && ctl.trigger_select && !busy |=>
      conv_start && state == adc_pkg::ADC_SAMPLE)
    else $error("trigger edge did not start");
  chk_edge_drop: assert property (@(posedge clk) disable iff (rst)
    s_hw_edge_busy |=> !conv_start || $past(finish))
    else $error("busy trigger edge restarted");
endmodule : adc_digital_control
`default_nettype wire

// ### rtl/adc_pkg.sv
// Purpose: constants, register map and carriers for the converter control
// Assumes: 8-bit register port, one clock at 20 MHz
// Notes:
// Function
// - 10-bit compare uses compare-high bits 1:0 against result bits 9:8
// - 8-bit compare ignores compare-high register
// - compare-low eight bits meet result low eight bits in every mode
// - config bit 7 picks high-speed (0) or low-power (1) profile
// - config bits 6:5 divide source clock by 1, 2, 4 or 8
// - config bit 4 picks short (0) or long (1) sample time
// - source select picks bus, bus/2, alternate or internal async clock
// - source select resets to the undivided bus clock
// - internal async clock keeps running in wait and stop
// - pin-control bit forces pin output driver to high impedance
// - pin-control bit disables input buffer, port reads zero
// - pin-control bit switches off the pin pull-up
// - trigger select 1 starts conversion on a hardware trigger rise while not busy
// - trigger rise during a conversion is discarded
// - continuous series launched only by the first trigger rise
// - mode field sets 12, 10 or 8 bits; software or hardware start
// - hardware trigger works with every mode and option
`default_nettype none
package adc_pkg;
  localparam int PINS = 24;
  // register indices
  localparam logic [3:0] REG_CVH  = 4'h0;
  localparam logic [3:0] REG_CVL  = 4'h1;
  localparam logic [3:0] REG_CFG  = 4'h2;
  localparam logic [3:0] REG_CTL  = 4'h3;
  localparam logic [3:0] REG_STAT = 4'h4;
  localparam logic [3:0] REG_RESH = 4'h5;
  localparam logic [3:0] REG_RESL = 4'h6;
  localparam logic [3:0] REG_PC1  = 4'h7;
  localparam logic [3:0] REG_PC2  = 4'h8;
  localparam logic [3:0] REG_PC3  = 4'h9;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam int CTL_START = 0;
  // modes and clock sources
  localparam logic [1:0] MODE_8   = 2'h0;
  localparam logic [1:0] MODE_12  = 2'h1;
  localparam logic [1:0] MODE_10  = 2'h2;
  localparam logic [1:0] SRC_BUS  = 2'h0;
  localparam logic [1:0] SRC_BUS2 = 2'h1;
  localparam logic [1:0] SRC_ALT  = 2'h2;
  localparam logic [1:0] SRC_ASYN = 2'h3;
  // converter clock edges (half periods) per phase
  localparam logic [4:0] SAMPLE_SHORT = 5'h04;
  localparam logic [4:0] SAMPLE_LONG  = 5'h18;
  localparam logic [4:0] BITS_12 = 5'h0c;
  localparam logic [4:0] BITS_10 = 5'h0a;
  localparam logic [4:0] BITS_8  = 5'h08;
  localparam logic [1:0] ASYNC_DIV = 2'h3;
  typedef struct packed {
    logic       low_power_select;
    logic [1:0] clock_divide_select;
    logic       long_sample_select;
    logic [1:0] mode;
    logic [1:0] clock_source_select;
  } adc_cfg_t;
  typedef struct packed {
    logic [2:0] spare;
    logic       cmp_ge;
    logic       trigger_select;
    logic       cmp_en;
    logic       continuous;
    logic       start;
  } adc_ctl_t;
  typedef enum logic [1:0] {
    ADC_IDLE   = 2'b00,
    ADC_SAMPLE = 2'b01,
    ADC_CONV   = 2'b10
  } adc_state_t;
endpackage : adc_pkg
`default_nettype wire

// ### sim/adc_analog_model.sv
// Purpose: analog core and pin pads facing the converter control
// Assumes: one clock domain, the bench clock
// Notes: a released pin without pull-up shows a level flipping each cycle
`default_nettype none
module adc_analog_model (
  input  wire logic                     clk,
  input  wire logic                     conv_start,
  input  wire logic [11:0]              next_value,
  input  wire logic [adc_pkg::PINS-1:0] pin_out,
  input  wire logic [adc_pkg::PINS-1:0] pin_oe_n,
  input  wire logic [adc_pkg::PINS-1:0] pin_pullup,
  output logic [11:0]                   conv_result,
  output logic                          alternate_clock,
  output logic [adc_pkg::PINS-1:0]      pin_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [adc_pkg::PINS-1:0] float_lvl;
  logic [1:0]               alt_cnt;
  initial
  begin
    conv_result     = 12'h000;
    alternate_clock = 1'h0;
    float_lvl       = 24'h5a5a5a;
    alt_cnt         = 2'h0;
  end
  // take the sample value when a conversion begins
  always @(posedge clk)
  begin
    if (conv_start)
      conv_result <= next_value;
  end
  // alternate clock runs at one sixth of the bus clock
  always @(posedge clk)
  begin
    alt_cnt   <= (alt_cnt == 2'h2) ? 2'h0 : alt_cnt + 2'h1;
    float_lvl <= ~float_lvl;
    if (alt_cnt == 2'h2)
      alternate_clock <= ~alternate_clock;
  end
  // pad level: driver, else pull-up, else a floating level
  assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & pin_pullup)
                | (pin_oe_n & ~pin_pullup & float_lvl);
endmodule : adc_analog_model
`default_nettype wire

// ### sim/adc_digital_control_tb_top.sv
// Purpose: self-checking bench for the converter control
// Assumes: analog model on the far side, 50 ns clock
// Notes: random values from a fixed seed
`default_nettype none
module adc_digital_control_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic                     clk, rst, wr_en, rd_en, stop_mode;
  logic [3:0]               addr;
  logic [7:0]               wr_data, rd_data;
  logic                     alternate_clock, hw_trigger_input;
  logic [11:0]              conv_result, next_value;
  logic                     converter_clock, conv_start, busy, cmp_match;
  logic                     low_power_select, long_sample_select;
  logic [adc_pkg::PINS-1:0] port_out, port_oe_n, port_pullup, pin_in;
  logic [adc_pkg::PINS-1:0] pin_out, pin_oe_n, pin_pullup, port_read;
  int                       err_count, total_checks, cycles, starts;
  int                       busy_cycles;
  integer                   seed;

  adc_digital_control dut (
    .clk(clk), .rst(rst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
    .rd_en(rd_en), .rd_data(rd_data), .alternate_clock(alternate_clock),
    .stop_mode(stop_mode), .hw_trigger_input(hw_trigger_input),
    .conv_result(conv_result), .converter_clock(converter_clock),
    .conv_start(conv_start), .busy(busy), .cmp_match(cmp_match),
    .low_power_select(low_power_select),
    .long_sample_select(long_sample_select), .port_out(port_out),
    .port_oe_n(port_oe_n), .port_pullup(port_pullup), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_pullup(pin_pullup),
    .port_read(port_read)
  );
  adc_analog_model model (
    .clk(clk), .conv_start(conv_start), .next_value(next_value),
    .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_pullup(pin_pullup),
    .conv_result(conv_result), .alternate_clock(alternate_clock),
    .pin_in(pin_in)
  );

  // -----------------------------------------------------------------
  // clock, hang limit and start counting
  // -----------------------------------------------------------------
  initial
  begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cycles++;
    if (conv_start === 1'h1)
      starts++;
    if (busy === 1'h1)
      busy_cycles++;
    if (cycles == 60000)
    begin
      err_count++;
      test_done();
    end
  end

  // -----------------------------------------------------------------
  // shared tasks and expectations
  // -----------------------------------------------------------------
  task automatic check(input string what, input logic [23:0] seen,
                       input logic [23:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr    <= a;
    wr_data <= d;
    wr_en   <= 1'h1;
    @(posedge clk);
    wr_en   <= 1'h0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    rd_en <= 1'h1;
    @(posedge clk);
    rd_en <= 1'h0;
    @(negedge clk);
    d = rd_data;
  endtask : rd
  task automatic wait_busy(input logic lvl);
    int n;
    n = 0;
    while (busy !== lvl && n < 5000)
    begin
      @(negedge clk);
      n++;
    end
    check("busy", {23'h0, busy}, {23'h0, lvl});
  endtask : wait_busy
  task automatic count_ticks(output int t);
    logic last;
    t = 0;
    @(negedge clk);
    last = converter_clock;
    repeat (128)
    begin
      @(negedge clk);
      if (converter_clock !== last)
        t++;
      last = converter_clock;
    end
  endtask : count_ticks
  function automatic logic cmp_exp(input logic [1:0] m,
    input logic [7:0] h, input logic [7:0] l, input logic [11:0] r,
    input logic ge, input logic en);
    logic [11:0] cv, rv;
    cv = (m == adc_pkg::MODE_12) ? {h[3:0], l} :
         (m == adc_pkg::MODE_10) ? {2'h0, h[1:0], l} : {4'h0, l};
    rv = (m == adc_pkg::MODE_12) ? r :
         (m == adc_pkg::MODE_10) ? {2'h0, r[9:0]} : {4'h0, r[7:0]};
    return en & (ge ? (rv >= cv) : (rv < cv));
  endfunction : cmp_exp
  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : test_done

  // -----------------------------------------------------------------
  // main sequence
  // -----------------------------------------------------------------
  initial
  begin
    logic [7:0]  d, h, l, q;
    logic [23:0] pcm;
    logic [1:0]  src, dv;
    int          s0, t, e;
    logic        stp;
    seed = 32'hb1e3;
    {rst, wr_en, rd_en, stop_mode, hw_trigger_input} = 5'h10;
    {addr, wr_data, next_value} = 24'h0;
    {port_out, port_oe_n, port_pullup} = 72'h0;
    {err_count, total_checks, cycles, starts} = '0;
    repeat (4) @(posedge clk);
    rst <= 1'h0;
    // reset values, read-back and an unmapped index
    for (int i = 0; i < 16; i++)
    begin
      rd(i[3:0], q);
      check("reset value", {16'h0, q}, 24'h0);
    end
    for (int i = 0; i < 3; i++)
    begin
      d = $random(seed);
      wr(i[3:0], d);
      rd(i[3:0], q);
      check("reg readback", {16'h0, q}, {16'h0, d});
    end
    check("low power", {23'h0, low_power_select}, {23'h0, d[7]});
    check("long sample", {23'h0, long_sample_select}, {23'h0, d[4]});
    wr(4'hb, 8'hff);
    rd(4'hb, q);
    check("unmapped", {16'h0, q}, 24'h0);
    $display("test registers done");
    // pin control against random port settings
    for (int k = 0; k < 4; k++)
    begin
      @(posedge clk);
      port_out    <= $random(seed);
      port_oe_n   <= $random(seed);
      port_pullup <= $random(seed);
      pcm = (k == 0) ? 24'h0 : (k == 3) ? 24'hffffff : $random(seed);
      wr(adc_pkg::REG_PC1, pcm[7:0]);
      wr(adc_pkg::REG_PC2, pcm[15:8]);
      wr(adc_pkg::REG_PC3, pcm[23:16]);
      repeat (3) @(negedge clk);
      check("pin release", pin_oe_n, port_oe_n | pcm);
      check("pin out", pin_out, port_out);
      check("pin pullup", pin_pullup, port_pullup & ~pcm);
      check("port read off", port_read & pcm, 24'h0);
      check("port read on", port_read & ~pcm & ~port_oe_n,
            port_out & ~pcm & ~port_oe_n);
    end
    $display("test pins done");
    // compare in every mode, equal value as corner
    for (int k = 0; k < 10; k++)
    begin
      h = $random(seed);
      l = $random(seed);
      d = $random(seed);
      next_value = (k == 1) ? {h[3:0], l} : 12'($random(seed));
      wr(adc_pkg::REG_CVH, h);
      wr(adc_pkg::REG_CVL, l);
      wr(adc_pkg::REG_CFG, {d[7:4], k[1:0], 2'h0});
      s0 = busy_cycles;
      wr(adc_pkg::REG_CTL, {3'h0, d[0], 1'h0, k != 0, 2'h1});
      wait_busy(1'h1);
      wait_busy(1'h0);
      check("compare", {23'h0, cmp_match}, {23'h0,
            cmp_exp(k[1:0], h, l, next_value, d[0], k != 0)});
      // busy spans sample plus bit ticks, each tick one divided period
      e = int'(d[4] ? adc_pkg::SAMPLE_LONG : adc_pkg::SAMPLE_SHORT)
        + int'((k[1:0] == adc_pkg::MODE_12) ? adc_pkg::BITS_12
        : (k[1:0] == adc_pkg::MODE_10) ? adc_pkg::BITS_10 : adc_pkg::BITS_8);
      t = busy_cycles - s0;
      check("conv length", {23'h0, t > ((e - 1) << d[6:5]) &&
            t <= (e << d[6:5])}, 24'h1);
      rd(adc_pkg::REG_STAT, q);
      check("status", {16'h0, q}, {21'h0,
            cmp_exp(k[1:0], h, l, next_value, d[0], k != 0), 2'h2});
      rd(adc_pkg::REG_RESL, q);
      check("result low", {16'h0, q}, {16'h0, next_value[7:0]});
      pcm = (k[1:0] == adc_pkg::MODE_12) ? {20'h0, next_value[11:8]}
          : (k[1:0] == adc_pkg::MODE_10) ? {22'h0, next_value[9:8]} : 24'h0;
      rd(adc_pkg::REG_RESH, q);
      check("result high", {16'h0, q}, pcm);
    end
    $display("test compare done");
    // hardware trigger in 10-bit long-sample mode
    wr(adc_pkg::REG_CFG, 8'h18);
    wr(adc_pkg::REG_CTL, 8'h0c);
    s0 = starts;
    wr(adc_pkg::REG_CTL, 8'h0d);
    repeat (6) @(posedge clk);
    check("sw start blocked", 24'(starts - s0), 24'h0);
    hw_trigger_input <= 1'h1;
    wait_busy(1'h1);
    @(posedge clk);
    hw_trigger_input <= 1'h0;
    repeat (4) @(posedge clk);
    hw_trigger_input <= 1'h1;
    wait_busy(1'h0);
    check("edge in busy", 24'(starts - s0), 24'h1);
    check("trig compare", {23'h0, cmp_match}, {23'h0,
          cmp_exp(2'h2, h, l, next_value, 1'h0, 1'h1)});
    repeat (8) @(posedge clk);
    check("level held", 24'(starts - s0), 24'h1);
    hw_trigger_input <= 1'h0;
    repeat (4) @(posedge clk);
    hw_trigger_input <= 1'h1;
    wait_busy(1'h1);
    wait_busy(1'h0);
    check("second edge", 24'(starts - s0), 24'h2);
    wr(adc_pkg::REG_CTL, 8'h00);
    $display("test trigger done");
    // converter clock rate per source, divider and stop
    for (int k = 0; k < 14; k++)
    begin
      stp = (k >= 12);
      src = (k == 12) ? adc_pkg::SRC_ASYN : (k == 13) ? adc_pkg::SRC_BUS
          : k[1:0];
      dv  = stp ? 2'h3 : k[3:2];
      e   = (src == 2'h0) ? 1 : (src == 2'h1) ? 2 : (src == 2'h2) ? 6 : 4;
      e   = (stp && src != adc_pkg::SRC_ASYN) ? 0 : 128 / (e << dv);
      wr(adc_pkg::REG_CFG, {1'h0, dv, 3'h0, src});
      stop_mode <= stp;
      wr(adc_pkg::REG_CTL, 8'h03);
      repeat (16) @(posedge clk);
      count_ticks(t);
      check("tick count", {23'h0, ((t > e ? t - e : e - t) <= 1)},
            24'h1);
      @(posedge clk);
      stop_mode <= 1'h0;
      wr(adc_pkg::REG_CTL, 8'h00);
      wait_busy(1'h0);
    end
    $display("test clocks done");
    // reset in mid-run must bring the clock back to the undivided bus clock
    @(posedge clk);
    rst <= 1'h1;
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    rd(adc_pkg::REG_CFG, q);
    check("reset source", {16'h0, q}, 24'h0);
    $display("test reset done");
    test_done();
  end
endmodule : adc_digital_control_tb_top
`default_nettype wire
